// *** design/dwp_pkg.sv ***
package dwp_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CORE_CLK_HZ            = 20_000_000;
    localparam int CLK_PERIOD_NS          = 50;
    localparam int GLITCH_NS              = 50;
    localparam int GLITCH_CYC             = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NV_WRITE_CYCLE_TIME_MS = 20;
    localparam int NV_WRITE_CYCLES        = NV_WRITE_CYCLE_TIME_MS * (CORE_CLK_HZ / 1000);
    // ************************************************************
    // Bus identity and register map
    // ************************************************************
    localparam logic [3:0] ID_PATTERN  = 4'ha;
    localparam logic [3:0] ADDR_WIPER0 = 4'h0;
    localparam logic [3:0] ADDR_WIPER1 = 4'h1;
    localparam logic [3:0] ADDR_RSVD   = 4'h7;
    localparam logic [3:0] ADDR_ACR    = 4'h8;
    localparam int         ACR_VOL_BIT  = 7;
    localparam int         ACR_POWER_DOWN_N_BIT = 6;
    localparam int         ACR_WIP_BIT  = 5;
    localparam logic       ACR_VOL_RST  = 1'h0;
    localparam logic       ACR_POWER_DOWN_N_RST = 1'h1;
    localparam logic [6:0] TAP_HIGH     = 7'h7f;
    localparam logic [6:0] TAP_LOW      = 7'h00;
    localparam logic [6:0] WIPER_PWRUP  = 7'h40;
    localparam logic [6:0] IVR_DEFAULT  = 7'h40;
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        PH_ID    = 3'h0,
        PH_ADDR  = 3'h1,
        PH_WDATA = 3'h3,
        PH_RDATA = 3'h2,
        PH_IGN   = 3'h6
    } dwp_phase_t;
    typedef struct packed {
        logic       tog;
        logic       is_addr;
        logic [7:0] data;
    } dwp_hand_t;
endpackage

// *** design/dwp_top.sv ***
`timescale 1ns/1ps
// Functional notes
// - Position 127 sits nearest the high terminal, 0 nearest the low terminal.
// - Each potentiometer has its own wiper register selecting its tap.
// - Shutdown opens the high terminal and ties each wiper to its low terminal.
// - Leaving shutdown restores the previous taps; wiper registers stay unchanged.
// - Shutdown pin low or control bit low, either alone, forces shutdown.
// - Serial interface and all registers stay usable during shutdown.
// - Incoming SDA bits are sampled on each rising SCL edge.
// - Read data changes SDA only after falling SCL edges, one bit per clock.
// - SDA is only pulled low or released, never driven high.
// - Three strap pins give the three low bits of the slave address.
// - Only a matching slave address starts a transfer; others are ignored.
// - A STOP ending a wiper write made with the volatile bit clear starts a self-timed non-volatile write cycle.
// - First byte is 1010, strap levels, then read/write bit.
// - Control bit 6 of the access control register, zero means shutdown, resets one.
// - Address 00h selects wiper 0, 01h selects wiper 1.
// - Wipers start at 40h, then reload from their initial value registers.

// ************************************************************
// Link side, clocked by SCL
// ************************************************************
module dwp_link (
    input  wire logic              scl_clk,
    input  wire logic              frame_rst_n,
    input  wire logic              sda_line,
    input  wire logic [2:0]        strap,
    input  wire logic [7:0]        rd_word,
    output logic                   sda_oe,
    output dwp_pkg::dwp_hand_t     hand,
    output logic                   rd_tog
);
    typedef struct packed {
        dwp_pkg::dwp_phase_t ph;
        logic [3:0]          cnt;
        logic [7:0]          sh;
        logic [7:0]          out_sh;
        logic                rw;
        logic                ack_req;
        dwp_pkg::dwp_hand_t  hand;
        logic                rd_tog;
    } dwp_link_st_t;

    dwp_link_st_t r;
    dwp_link_st_t n;
    logic [7:0]   byte_in;
    assign byte_in = {r.sh[6:0], sda_line};
    assign hand    = r.hand;
    assign rd_tog  = r.rd_tog;

    always_comb begin
        n = r;
        if (r.cnt == 4'h8) begin
            n.cnt     = 4'h0;
            n.ack_req = 1'b0;
            case (r.ph)
                dwp_pkg::PH_ID:    n.ph = r.rw ? dwp_pkg::PH_RDATA : dwp_pkg::PH_ADDR;
                dwp_pkg::PH_ADDR:  n.ph = dwp_pkg::PH_WDATA;
                dwp_pkg::PH_RDATA: n.ph = sda_line ? dwp_pkg::PH_IGN : dwp_pkg::PH_RDATA;
                default:           n.ph = r.ph;
            endcase
            if (n.ph == dwp_pkg::PH_RDATA) begin
                n.out_sh = rd_word;
                n.rd_tog = ~r.rd_tog;
            end
        end else begin
            n.cnt = r.cnt + 4'h1;
            n.sh  = byte_in;
            if (r.cnt == 4'h7) begin
                case (r.ph)
                    dwp_pkg::PH_ID: begin
                        if (byte_in[7:1] == {dwp_pkg::ID_PATTERN, strap}) begin
                            n.ack_req = 1'b1;
                            n.rw      = byte_in[0];
                        end else begin
                            n.ph = dwp_pkg::PH_IGN;
                        end
                    end
                    dwp_pkg::PH_ADDR, dwp_pkg::PH_WDATA: begin
                        n.ack_req      = 1'b1;
                        n.hand.tog     = ~r.hand.tog;
                        n.hand.is_addr = (r.ph == dwp_pkg::PH_ADDR);
                        n.hand.data    = byte_in;
                    end
                    default: ;
                endcase
            end
        end
    end

    // The frame reset is released by the core while SCL is low, far from any edge.
    always_ff @(posedge scl_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Only the enable is driven; a high level always comes from the pull-up.
    always_ff @(negedge scl_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            sda_oe <= 1'b0;
        end else if (r.ack_req) begin
            sda_oe <= 1'b1;
        end else if (r.ph == dwp_pkg::PH_RDATA && r.cnt < 4'h8) begin
            sda_oe <= ~r.out_sh[~r.cnt[2:0]];
        end else begin
            sda_oe <= 1'b0;
        end
    end

    default clocking cb_link @(posedge scl_clk);
    endclocking
    default disable iff (!frame_rst_n);

    a_id_mismatch: assert property (
        (r.ph == dwp_pkg::PH_ID && r.cnt == 4'h7 && byte_in[7:1] != {dwp_pkg::ID_PATTERN, strap})
        |=> r.ph == dwp_pkg::PH_IGN)
        else $error("Foreign address was not ignored.");
    a_ack_drive: assert property (r.ack_req |-> sda_oe)
        else $error("Acknowledge slot not pulled low.");
    a_ign_silent: assert property (r.ph == dwp_pkg::PH_IGN |-> !sda_oe)
        else $error("SDA pulled during an ignored transfer.");
endmodule // dwp_link

// ************************************************************
// Core side, clocked by core_clk
// ************************************************************
module dwp_top #(
    parameter int         NV_CYCLES = dwp_pkg::NV_WRITE_CYCLES,
    parameter logic [6:0] IVR_INIT  = dwp_pkg::IVR_DEFAULT
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       scl_clk,
    input  wire logic       sda_line,
    output logic            sda_low,
    output logic            sda_oe,
    input  wire logic [2:0] address_strap_pins,
    input  wire logic       power_down_n,
    output logic [6:0]      wiper_position_reg_0,
    output logic [6:0]      wiper_position_reg_1,
    output logic            high_terminal_open,
    output logic            wiper_to_low,
    output logic            write_in_progress
);
    localparam int NVW = $clog2(NV_CYCLES + 1);
    if (NV_CYCLES < 1 || dwp_pkg::GLITCH_CYC > 3) begin : g_bad_param
        $error("Unsupported write cycle or glitch count.");
    end
    typedef struct packed {
        logic [1:0]      scl_s;
        logic [1:0]      sda_s;
        logic [1:0]      pd_s;
        logic [2:0]      strap_s1;
        logic [2:0]      strap_s2;
        logic [1:0]      filt;
        logic [1:0][1:0] fcnt;
        logic [2:0]      strap;
        logic            frame_on;
        logic            link_run;
        logic [2:0]      hsy;
        logic [2:0]      rsy;
        logic [3:0]      ptr;
        logic [1:0][6:0] wiper;
        logic [1:0][6:0] initial_value_reg;
        logic            vol;
        logic            power_down_n_bit;
        logic            wip;
        logic            nv_pend;
        logic            recall_done;
        logic            shut;
        logic [NVW-1:0]  nv_cnt;
        logic [7:0]      rd_word;
    } dwp_core_st_t;

    localparam dwp_core_st_t ST_RST = '{
        scl_s:    2'h3,
        sda_s:    2'h3,
        filt:     2'h3,
        wiper:    {2{dwp_pkg::WIPER_PWRUP}},
        initial_value_reg:      {2{IVR_INIT}},
        vol:      dwp_pkg::ACR_VOL_RST,
        power_down_n_bit: dwp_pkg::ACR_POWER_DOWN_N_RST,
        default:  '0
    };

    dwp_core_st_t       r;
    dwp_core_st_t       n;
    dwp_pkg::dwp_hand_t hand_w;
    logic               rtog_w;
    logic               hev;
    logic               rev;
    logic               start_ev;
    logic               stop_ev;
    logic [1:0]         raw;

    function automatic logic [3:0] ptr_step(input logic [3:0] p);
        return (p == dwp_pkg::ADDR_ACR) ? dwp_pkg::ADDR_WIPER0
             : (p > dwp_pkg::ADDR_ACR) ? p : p + 4'h1;
    endfunction

    dwp_link u_link (
        .scl_clk     (scl_clk),
        .frame_rst_n (r.link_run),
        .sda_line    (sda_line),
        .strap       (r.strap),
        .rd_word     (r.rd_word),
        .sda_oe      (sda_oe),
        .hand        (hand_w),
        .rd_tog      (rtog_w)
    );

    assign raw      = {r.scl_s[1], r.sda_s[1]};
    assign hev      = r.hsy[2] ^ r.hsy[1];
    assign rev      = r.rsy[2] ^ r.rsy[1];
    always_comb begin
        n          = r;
        n.scl_s    = {r.scl_s[0], scl_clk};
        n.sda_s    = {r.sda_s[0], sda_line};
        n.pd_s     = {r.pd_s[0], power_down_n};
        n.strap_s1 = address_strap_pins;
        n.strap_s2 = r.strap_s1;
        // A frame reset clears the link's toggles; following it here hides the false edge.
        n.hsy      = r.link_run ? {r.hsy[1:0], hand_w.tog} : 3'h0;
        n.rsy      = r.link_run ? {r.rsy[1:0], rtog_w} : 3'h0;
        // A change must persist past the suppression time before it is believed.
        for (int k = 0; k < 2; k++) begin
            if (raw[k] == r.filt[k]) begin
                n.fcnt[k] = 2'h0;
            end else if (r.fcnt[k] == 2'(dwp_pkg::GLITCH_CYC)) begin
                n.filt[k] = raw[k];
                n.fcnt[k] = 2'h0;
            end else begin
                n.fcnt[k] = r.fcnt[k] + 2'h1;
            end
        end
        start_ev = r.filt[1] && n.filt[1] && r.filt[0] && !n.filt[0];
        stop_ev  = r.filt[1] && n.filt[1] && !r.filt[0] && n.filt[0];
        if (start_ev) begin
            n.frame_on = 1'b1;
            n.link_run = 1'b0;
            n.strap    = r.strap_s2;
        end else if (stop_ev) begin
            n.frame_on = 1'b0;
            n.link_run = 1'b0;
        end else if (r.frame_on && !r.filt[1]) begin
            n.link_run = 1'b1;
        end
        if (!r.recall_done) begin
            n.wiper       = r.initial_value_reg;
            n.recall_done = 1'b1;
        end
        // Writes stay legal in shutdown; only a running non-volatile cycle (wip) locks them.
        if (hev && hand_w.is_addr) begin
            n.ptr = (hand_w.data[7:4] != 4'h0) ? dwp_pkg::ADDR_RSVD : hand_w.data[3:0];
        end else if (hev) begin
            if (!r.wip && r.ptr <= dwp_pkg::ADDR_WIPER1) begin
                n.wiper[r.ptr[0]] = hand_w.data[6:0];
                if (!r.vol) begin
                    n.initial_value_reg[r.ptr[0]] = hand_w.data[6:0];
                    n.nv_pend       = 1'b1;
                end
            end else if (!r.wip && r.ptr == dwp_pkg::ADDR_ACR) begin
                n.vol      = hand_w.data[dwp_pkg::ACR_VOL_BIT];
                n.power_down_n_bit = hand_w.data[dwp_pkg::ACR_POWER_DOWN_N_BIT];
            end
            n.ptr = ptr_step(r.ptr);
        end else if (rev) begin
            n.ptr = ptr_step(r.ptr);
        end
        if (stop_ev && r.nv_pend) begin
            n.wip     = 1'b1;
            n.nv_pend = 1'b0;
            n.nv_cnt  = NVW'(NV_CYCLES - 1);
        end else if (r.wip && r.nv_cnt == '0) begin
            n.wip = 1'b0;
        end else if (r.wip) begin
            n.nv_cnt = r.nv_cnt - NVW'(1);
        end
        n.shut = !r.pd_s[1] || !r.power_down_n_bit;
        n.rd_word = 8'h00;
        if (n.ptr <= dwp_pkg::ADDR_WIPER1) begin
            n.rd_word = {1'b0, n.vol ? n.wiper[n.ptr[0]] : n.initial_value_reg[n.ptr[0]]};
        end else if (n.ptr == dwp_pkg::ADDR_ACR) begin
            n.rd_word[dwp_pkg::ACR_VOL_BIT]  = n.vol;
            n.rd_word[dwp_pkg::ACR_POWER_DOWN_N_BIT] = n.power_down_n_bit;
            n.rd_word[dwp_pkg::ACR_WIP_BIT]  = n.wip;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= ST_RST;
        end else begin
            r <= n;
        end
    end

    // Taps pass untouched in shutdown; the switch array applies the open and short.
    assign wiper_position_reg_0 = r.wiper[0];
    assign wiper_position_reg_1 = r.wiper[1];
    assign high_terminal_open   = r.shut;
    assign wiper_to_low         = r.shut;
    assign write_in_progress    = r.wip;
    assign sda_low              = 1'b0;

    default clocking cb_core @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_write_then_stop;
        r.nv_pend && stop_ev;
    endsequence

    a_pin_shutdown: assert property (!r.pd_s[1] |=> high_terminal_open && wiper_to_low)
        else $error("Shutdown pin did not force shutdown.");
    a_bit_shutdown: assert property (!r.power_down_n_bit |=> high_terminal_open && wiper_to_low)
        else $error("Shutdown bit did not force shutdown.");
    a_shut_release: assert property ((r.pd_s[1] && r.power_down_n_bit) |=> !high_terminal_open)
        else $error("Shutdown held without a request.");
    a_wiper_hold: assert property ((r.shut && r.recall_done && !hev) |=> $stable(r.wiper))
        else $error("Wiper changed during shutdown without a write.");
    a_ivr_recall: assert property ($rose(r.recall_done) |-> r.wiper == r.initial_value_reg)
        else $error("Wipers not reloaded from initial values.");
    a_nv_start: assert property (s_write_then_stop |=> r.wip [*2])
        else $error("Non-volatile cycle did not start after STOP.");
    a_wip_lock: assert property ((r.wip && hev) |=> $stable(r.initial_value_reg) && $stable(r.vol))
        else $error("Register written during non-volatile cycle.");
    a_wiper_write: assert property (
        (hev && !hand_w.is_addr && r.ptr == dwp_pkg::ADDR_WIPER0 && !r.wip)
        |=> wiper_position_reg_0 == hand_w.data[6:0])
        else $error("Wiper 0 write lost.");
    a_start_frame: assert property (start_ev |=> r.frame_on && !r.link_run)
        else $error("START did not reset the link.");
endmodule // dwp_top

// *** testbench/dwp_i2c_master.sv ***
`timescale 1ns/1ps
// ************************************************************
// Bus master model
// ************************************************************
// The model only pulls SDA low or lets it go, so the pull-up decides every high level.
// SCL stands high between frames and never runs free.
module dwp_i2c_master #(
    parameter int Q = 810
) (
    output logic       scl,
    output logic       sda_pull,
    input  wire logic  sda_line,
    output logic [7:0] rd_byte,
    output logic       rd_done
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        rd_byte = 8'h00;
        rd_done = 1'b0;
    end
    // Start and repeated start; holds keep SCL low for at least two quarter steps.
    task automatic start_cond();
        sda_pull = 1'b0;
        #Q scl = 1'b1;
        #Q sda_pull = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask
    task automatic stop_cond();
        sda_pull = 1'b1;
        #Q scl = 1'b1;
        #Q sda_pull = 1'b0;
        #(2*Q);
    endtask
    // SDA changes only while SCL is low; the line is read in mid high phase.
    task automatic bit_io(input logic b, output logic r);
        sda_pull = !b;
        #Q scl = 1'b1;
        #Q r = sda_line;
        #Q scl = 1'b0;
        #Q;
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic get_byte(input logic last);
        logic       r;
        logic [7:0] d;
        d = 8'h00;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, r);
            d = {d[6:0], r};
        end
        bit_io(last, r);
        rd_byte = d;
        rd_done = !rd_done;
    endtask
endmodule // dwp_i2c_master

// *** testbench/dwp_top_tb.sv ***
`timescale 1ns/1ps
// ************************************************************
// Self-checking bench
// ************************************************************
module dwp_top_tb;
    localparam int         NV  = 3000;
    localparam logic [6:0] INITIAL_VALUE_REG = 7'h23;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       power_down_n = 1'b1;
    logic [2:0] strap;
    wire        scl;
    wire        sda_pull;
    wire [7:0]  rd_byte;
    wire        rd_done;
    logic       sda_low, sda_oe, hto, wtl, wip;
    logic [6:0] w0, w1;
    wire        sda_line = !(sda_pull || sda_oe);
    int         num_errors = 0;
    int         comparisons = 0;
    int         seed = 32'h73ec;
    int         wip_cnt = 0;
    logic [7:0] expq[$];
    logic       ack;
    logic [7:0] d0, d1;

    always #25 core_clk = !core_clk;

    dwp_top #(.NV_CYCLES(NV), .IVR_INIT(INITIAL_VALUE_REG)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .scl_clk(scl), .sda_line(sda_line),
        .sda_low(sda_low), .sda_oe(sda_oe), .address_strap_pins(strap),
        .power_down_n(power_down_n), .wiper_position_reg_0(w0),
        .wiper_position_reg_1(w1), .high_terminal_open(hto), .wiper_to_low(wtl),
        .write_in_progress(wip)
    );
    dwp_i2c_master m (
        .scl(scl), .sda_pull(sda_pull), .sda_line(sda_line),
        .rd_byte(rd_byte), .rd_done(rd_done)
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (10) @(negedge core_clk);
    endtask
    task automatic open_frame(input logic [7:0] a);
        m.start_cond();
        m.put_byte({dwp_pkg::ID_PATTERN, strap, 1'b0}, ack);
        check("ack_id", {7'h00, ack}, 8'h01);
        m.put_byte(a, ack);
        check("ack_addr", {7'h00, ack}, 8'h01);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1, input int n);
        open_frame(a);
        for (int i = 0; i < n; i++) begin
            m.put_byte(i ? e1 : e0, ack);
            check("ack_data", {7'h00, ack}, 8'h01);
        end
        m.stop_cond();
        settle();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1, input int n);
        open_frame(a);
        m.start_cond();
        m.put_byte({dwp_pkg::ID_PATTERN, strap, 1'b1}, ack);
        check("ack_rd_id", {7'h00, ack}, 8'h01);
        for (int i = 0; i < n; i++) begin
            expq.push_back(i ? e1 : e0);
            m.get_byte(i == n - 1);
        end
        m.stop_cond();
        settle();
    endtask

    always @(rd_done) begin
        if (rst_n && expq.size() > 0) begin
            check("read_data", rd_byte, expq.pop_front());
        end
    end
    always @(sda_oe) begin
        if (rst_n) begin
            check("oe_scl_low", {7'h00, scl}, 8'h00);
            check("sda_low", {7'h00, sda_low}, 8'h00);
        end
    end
    always @(negedge core_clk) begin
        if (wip) begin
            wip_cnt++;
        end
    end

    initial begin
        #(90_000 * 50);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        strap = 3'($random(seed));
        repeat (5) @(negedge core_clk);
        check("w0_reset", {1'b0, w0}, {1'b0, dwp_pkg::WIPER_PWRUP});
        rst_n = 1'b1;
        repeat (6) @(negedge core_clk);
        check("w0_recall", {1'b0, w0}, {1'b0, INITIAL_VALUE_REG});
        check("w1_recall", {1'b0, w1}, {1'b0, INITIAL_VALUE_REG});
        check("shut_idle", {7'h00, hto}, 8'h00);
        // With the volatile bit clear a wiper write also lands in the initial value register.
        wr(8'h00, 8'h11, 8'h00, 1);
        check("wip_on", {7'h00, wip}, 8'h01);
        // Still inside the non-volatile cycle: the byte is acknowledged and then dropped.
        wr(8'h00, 8'h22, 8'h00, 1);
        check("w0_locked", {1'b0, w0}, 8'h11);
        repeat (NV) @(negedge core_clk);
        check("w0_ivr", {1'b0, w0}, 8'h11);
        check("wip_len", {7'h00, wip_cnt == NV}, 8'h01);
        rd(8'h00, 8'h11, 8'h00, 1);
        rd(8'h08, 8'h40, 8'h00, 1);
        wr(8'h08, 8'hc0, 8'h33, 2);
        check("w0_wrap", {1'b0, w0}, 8'h33);
        m.start_cond();
        m.put_byte({dwp_pkg::ID_PATTERN, strap ^ 3'h5, 1'b0}, ack);
        check("nack_id", {7'h00, ack}, 8'h00);
        m.stop_cond();
        settle();
        wr(8'h00, 8'h7f, 8'h00, 2);
        check("w0_high", {1'b0, w0}, {1'b0, dwp_pkg::TAP_HIGH});
        check("w1_low", {1'b0, w1}, {1'b0, dwp_pkg::TAP_LOW});
        for (int i = 0; i < 3; i++) begin
            d0 = {1'b0, 7'($random(seed))};
            d1 = {1'b0, 7'($random(seed))};
            wr(8'h00, d0, d1, 2);
            check("w0_rand", {1'b0, w0}, d0);
            check("w1_rand", {1'b0, w1}, d1);
            rd(8'h00, d0, d1, 2);
        end
        wr(8'h08, 8'h80, 8'h00, 1);
        check("hto_bit", {7'h00, hto}, 8'h01);
        check("wtl_bit", {7'h00, wtl}, 8'h01);
        check("w0_kept", {1'b0, w0}, d0);
        wr(8'h01, 8'h5a, 8'h00, 1);
        check("w1_shut", {1'b0, w1}, 8'h5a);
        rd(8'h08, 8'h80, 8'h00, 1);
        wr(8'h08, 8'hc0, 8'h00, 1);
        check("hto_off", {7'h00, hto}, 8'h00);
        check("w1_back", {1'b0, w1}, 8'h5a);
        power_down_n = 1'b0;
        repeat (6) @(negedge core_clk);
        check("hto_pin", {7'h00, hto}, 8'h01);
        check("wtl_pin", {7'h00, wtl}, 8'h01);
        power_down_n = 1'b1;
        repeat (6) @(negedge core_clk);
        check("hto_pin_off", {7'h00, hto}, 8'h00);
        // With the volatile bit cleared again, reads return the initial value registers.
        wr(8'h08, 8'h40, 8'h00, 1);
        rd(8'h00, 8'h11, {1'b0, INITIAL_VALUE_REG}, 2);
        tally_and_finish();
    end
endmodule // dwp_top_tb
